// ==== hdl/bdma_pkg.sv ====
// Functional notes
// - Error sets PCI or local error flag
// - Local write error waits for watermark level
// - PCI read error: stop prefetch, flag, negate
// - Local read error: negate, stop, flag, interrupt
// - PCI write error: halt writes, flag, negate
// - Local write error: negate, flag, drain cachelines
// - Four sources with enable, direction, status
// - Flags clear on write one; irq holds
// - Errored transfer needs reset before restart
// - Slave channel unaffected by channel errors
// - Reset request ignored unless active
// - Reset first negates transfer request line
// - Reset ends write at cacheline, read immediately
// - Flush FIFO after frame negated
// - Reset clears active, sets flag, keeps fields
// - PCI little-endian; local order selectable, big default
// - Big swaps lanes; little keeps lanes
// - 16-bit port splits and packs words
// - 16-bit little: B3B2 then B1B0
// - 16-bit big: B0B1 then B2B3
// - 32-bit little maps lane for lane
// - 32-bit big reverses byte order
// - Active flag held during transfer
// - Request line asks processor DMA service
package bdma_pkg;
    localparam logic [11:0] ADDR_CS     = 12'h000;
    localparam logic [11:0] ADDR_PADD   = 12'h004;
    localparam logic [11:0] ADDR_CNT    = 12'h008;
    localparam logic [11:0] ADDR_INTEN  = 12'h00C;
    localparam logic [11:0] ADDR_INTDIR = 12'h010;
    localparam logic [11:0] ADDR_INTST  = 12'h014;
    localparam logic [11:0] ADDR_MISC   = 12'h018;
    localparam logic [11:0] ADDR_DATA   = 12'h01C;
    // Control/status bit positions.
    localparam int CS_GO   = 0;
    localparam int CS_DIR  = 1;
    localparam int CS_P16  = 2;
    localparam int CS_RREQ = 3;
    localparam int CS_ACT  = 8;
    localparam int CS_DONE = 9;
    localparam int CS_IPE  = 10;
    localparam int CS_IQE  = 11;
    localparam int CS_CHANNEL_RESET_FLAG = 12;
    localparam int CS_WM   = 16;
    localparam int WM_W    = 4;
    // Interrupt source order in enable, direction and status registers.
    localparam int SRC_RST  = 0;
    localparam int SRC_PE   = 1;
    localparam int SRC_QE   = 2;
    localparam int SRC_DONE = 3;
    localparam int MISC_BOC = 0;
    localparam logic MISC_BOC_RST = 1'b1;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AW    = 4;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    typedef enum logic [2:0] {
        BDMA_IDLE, BDMA_RUN, BDMA_DRAIN, BDMA_HALT, BDMA_FLUSH
    } bdma_state_t;
endpackage

// ==== hdl/bdma_fifo_if.sv ====
interface bdma_fifo_if;
    logic        wr_en;
    logic [3:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  rd_addr;
    logic [31:0] rd_data;
    modport ctl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
    modport mem (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface

// ==== hdl/bdma_fifo_mem.sv ====
module bdma_fifo_mem (
    input  wire logic clk_sys,   // System clock.
    bdma_fifo_if.mem  port       // Memory access port.
);
    logic [31:0] mem_r [16];
    logic [31:0] rd_r;
    always_ff @(posedge clk_sys) begin
        if (port.wr_en) begin
            mem_r[port.wr_addr] <= port.wr_data;
        end
        rd_r <= mem_r[port.rd_addr];
    end
    assign port.rd_data = rd_r;
endmodule // bdma_fifo_mem

// ==== hdl/bdma_top.sv ====
module bdma_top (
    input  wire logic        clk_sys,      // 250 MHz clock.
    input  wire logic        resetn,       // Async reset, active low.
    input  wire logic        psel,         // APB select.
    input  wire logic        penable,      // APB enable.
    input  wire logic        pwrite,       // APB write.
    input  wire logic [11:0] paddr,        // APB address.
    input  wire logic [31:0] pwdata,       // APB write data.
    output logic      [31:0] prdata,       // APB read data.
    output logic             pready,       // APB ready.
    output logic             pslverr,      // APB error.
    output logic             transfer_request_line, // Service request.
    input  wire logic        transfer_acknowledge,  // One local transfer.
    input  wire logic [31:0] local_wdata,  // Local write data lanes.
    output logic      [31:0] local_rdata,  // Local read data lanes.
    output logic      [1:0]  local_transfer_size, // Local size code.
    output logic      [1:0]  local_addr,   // Local A[1:0].
    input  wire logic        local_bus_error, // Local error pulse.
    output logic             pci_req,      // Ask PCI master for a word.
    input  wire logic        pci_ack,      // PCI word transferred.
    input  wire logic [31:0] pci_rdata,    // PCI read word.
    output logic      [31:0] pci_wdata,    // PCI write word.
    output logic      [3:0]  pci_be_n,     // PCI byte enables.
    output logic             pci_frame_end,   // Negate frame request.
    input  wire logic        pci_burst_active, // PCI burst in progress.
    input  wire logic        pci_line_end, // Cacheline boundary reached.
    input  wire logic        pci_error,    // PCI error pulse.
    output logic             irq_pci_r,    // Interrupt to PCI side.
    output logic             irq_local_r   // Interrupt to local side.
);
    import bdma_pkg::*;

    bdma_fifo_if fif ();
    bdma_fifo_mem u_mem (.clk_sys(clk_sys), .port(fif));

    bdma_state_t st_r, st_nxt;
    logic        dir_r, p16_r, boc_r, act_r, done_r, ipe_r, iqe_r, channel_reset_flag_r;
    logic [WM_W-1:0] wm_r;
    logic [31:0] padd_r, cnt_r;
    logic [3:0]  ien_r, idir_r;
    logic [FIFO_AW-1:0] wp_r, rp_r;
    logic [FIFO_AW:0]   lvl_r;
    logic        half_r, lerr_pend_r, rd_vld_r;
    logic [15:0] hold_r;

    // Bus decode.
    wire acc    = psel && penable;
    wire wr_acc = acc && pwrite;
    wire hit_cs = paddr == ADDR_CS;
    wire hit_pa = paddr == ADDR_PADD;
    wire hit_cn = paddr == ADDR_CNT;
    wire hit_ie = paddr == ADDR_INTEN;
    wire hit_id = paddr == ADDR_INTDIR;
    wire hit_is = paddr == ADDR_INTST;
    wire hit_mi = paddr == ADDR_MISC;
    wire hit_dt = paddr == ADDR_DATA;
    wire mapped = hit_cs | hit_pa | hit_cn | hit_ie | hit_id | hit_is
                  | hit_mi | hit_dt;
    wire cs_wr  = wr_acc && hit_cs;
    wire go_wr  = cs_wr && pwdata[CS_GO] && !act_r && !ipe_r && !iqe_r;
    wire rst_wr = cs_wr && pwdata[CS_RREQ] && act_r;

    // Source flags: status register view.
    wire [3:0] src = {done_r, iqe_r, ipe_r, channel_reset_flag_r};
    wire [3:0] istat = src & ien_r;
    wire [31:0] cs_view = {{(32-CS_WM-WM_W){1'b0}}, wm_r, 3'h0,
                           channel_reset_flag_r, iqe_r, ipe_r, done_r, act_r,
                           4'h0, 1'b0, p16_r, dir_r, 1'b0};

    // FIFO levels.
    wire full   = lvl_r == (FIFO_AW+1)'(FIFO_DEPTH);
    wire empty  = lvl_r == '0;
    wire at_wm  = lvl_r >= {1'b0, wm_r};
    wire errd   = ipe_r | iqe_r;
    wire run    = st_r == BDMA_RUN;

    // Byte lane mapping as a function so read and write share it.
    function automatic logic [31:0] swap32(input logic [31:0] w);
        swap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction
    function automatic logic [15:0] swap16(input logic [15:0] h);
        swap16 = {h[7:0], h[15:8]};
    endfunction

    // PCI read data -> FIFO (direction 0); local write -> FIFO (dir 1).
    wire lw_word  = dir_r && transfer_acknowledge && run && !errd;
    wire lw_push  = lw_word && (!p16_r || half_r);
    wire [31:0] lw_full = p16_r ? {hold_r, local_wdata[31:16]} : local_wdata;
    // Little: lanes kept, first half carries B3B2; big: bytes reversed.
    wire [31:0] lw_pci = boc_r ?
        (p16_r ? {swap16(lw_full[15:0]), swap16(lw_full[31:16])}
               : swap32(lw_full)) : lw_full;
    // Words that arrive after the count has run out are prefetch overrun:
    // they are dropped so a count that is a multiple of 4 never wraps below zero.
    wire cnt_live = cnt_r != WORD_ZERO;
    wire pr_push  = !dir_r && pci_ack && run && !ipe_r && !full
                    && cnt_live;
    wire push     = lw_push | pr_push;
    wire [31:0] push_d = dir_r ? lw_pci : pci_rdata;
    // Drain: local read (dir 0) or PCI write (dir 1).
    wire lr_pop   = !dir_r && transfer_acknowledge && run && !iqe_r
                    && rd_vld_r && (!p16_r || half_r);
    wire pw_pop   = dir_r && pci_ack && !ipe_r && !empty
                    && (run || st_r == BDMA_DRAIN);
    wire pop      = lr_pop | pw_pop;
    wire lr_beat  = !dir_r && transfer_acknowledge && run && rd_vld_r;

    // Transfer request.
    wire req_rd  = !dir_r && !empty && !iqe_r && !ipe_r;
    wire req_wr  = dir_r && !full && !iqe_r && !ipe_r;
    wire req_nxt = run && (req_rd || req_wr);
    // PCI master request: read prefetch or write at watermark.
    wire pci_nxt = (run && !dir_r && !full && !ipe_r && !iqe_r
                    && cnt_r != WORD_ZERO)
                 || (run && dir_r && at_wm && !empty && !ipe_r)
                 || (st_r == BDMA_DRAIN && !empty);
    wire cnt_dn  = pci_ack && (pr_push || pw_pop) && cnt_live;

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            BDMA_IDLE: if (go_wr) st_nxt = BDMA_RUN;
            BDMA_RUN: begin
                if (rst_wr) begin
                    st_nxt = BDMA_FLUSH;
                end else if (pci_error) begin
                    st_nxt = BDMA_HALT;
                end else if (lerr_pend_r && at_wm && dir_r) begin
                    st_nxt = pci_burst_active ? BDMA_DRAIN : BDMA_HALT;
                end else if (local_bus_error && !dir_r) begin
                    st_nxt = BDMA_HALT;
                end else if (cnt_r == WORD_ZERO && empty) begin
                    st_nxt = BDMA_IDLE;
                end
            end
            BDMA_DRAIN: begin
                if (rst_wr) st_nxt = BDMA_FLUSH;
                else if (lvl_r < 5'h04 || pci_error) st_nxt = BDMA_HALT;
            end
            BDMA_HALT: if (rst_wr) st_nxt = BDMA_FLUSH;
            BDMA_FLUSH: begin
                // Write bursts end on a line, reads stop at once.
                if (!pci_burst_active || !dir_r || pci_line_end) begin
                    st_nxt = BDMA_IDLE;
                end
            end
            default: st_nxt = BDMA_IDLE;
        endcase
    end

    wire fin_rst  = st_r == BDMA_FLUSH && st_nxt == BDMA_IDLE;
    wire fin_done = run && st_nxt == BDMA_IDLE;
    wire [31:0] rdmux =
        hit_cs ? cs_view : hit_pa ? padd_r : hit_cn ? cnt_r :
        hit_ie ? {28'h0, ien_r} : hit_id ? {28'h0, idir_r} :
        hit_is ? {28'h0, istat} : hit_mi ? {31'h0, boc_r} :
        hit_dt ? fif.rd_data : WORD_ZERO;

    assign fif.wr_en   = push;
    assign fif.wr_addr = wp_r;
    assign fif.wr_data = push_d;
    assign fif.rd_addr = pop ? rp_r + 4'h1 : rp_r;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_r <= BDMA_IDLE;
            {dir_r, p16_r, act_r, done_r, ipe_r, iqe_r, channel_reset_flag_r} <= '0;
            boc_r <= MISC_BOC_RST;
            wm_r <= '0; padd_r <= '0; cnt_r <= '0;
            ien_r <= '0; idir_r <= '0;
            wp_r <= '0; rp_r <= '0; lvl_r <= '0;
            half_r <= 1'b0; hold_r <= '0; lerr_pend_r <= 1'b0;
            rd_vld_r <= 1'b0;
            prdata <= '0; pready <= 1'b0; pslverr <= 1'b0;
            transfer_request_line <= 1'b0; pci_req <= 1'b0;
            pci_frame_end <= 1'b0; pci_wdata <= '0; pci_be_n <= 4'hF;
            local_rdata <= '0; local_transfer_size <= '0; local_addr <= '0;
            irq_pci_r <= 1'b0; irq_local_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            pready  <= psel && !pready;
            pslverr <= psel && !pready && !mapped;
            prdata  <= rdmux;
            if (cs_wr && !act_r) begin
                dir_r <= pwdata[CS_DIR];
                p16_r <= pwdata[CS_P16];
                wm_r  <= pwdata[CS_WM +: WM_W];
            end
            if (wr_acc && hit_pa && !act_r) padd_r <= pwdata;
            if (wr_acc && hit_ie) ien_r  <= pwdata[3:0];
            if (wr_acc && hit_id) idir_r <= pwdata[3:0];
            if (wr_acc && hit_mi) boc_r  <= pwdata[MISC_BOC];
            if (wr_acc && hit_cn && !act_r) cnt_r <= pwdata;
            else if (cnt_dn) cnt_r <= cnt_r - 32'h4;
            act_r <= (st_nxt != BDMA_IDLE);
            // Set wins over the write-one clear.
            done_r <= fin_done | (done_r & !(cs_wr & pwdata[CS_DONE]));
            channel_reset_flag_r <= fin_rst | (channel_reset_flag_r & !(cs_wr & pwdata[CS_CHANNEL_RESET_FLAG]));
            ipe_r  <= (act_r & pci_error)
                      | (ipe_r & !(cs_wr & pwdata[CS_IPE]));
            iqe_r  <= (act_r & ((local_bus_error & !dir_r) | (st_r ==
                      BDMA_RUN & st_nxt != BDMA_RUN & lerr_pend_r)))
                      | (iqe_r & !(cs_wr & pwdata[CS_IQE]));
            lerr_pend_r <= run && dir_r && (lerr_pend_r || local_bus_error);
            if (st_r == BDMA_FLUSH || go_wr) begin
                wp_r <= '0; rp_r <= '0; lvl_r <= '0;
                half_r <= 1'b0; rd_vld_r <= 1'b0;
            end else begin
                if (push) wp_r <= wp_r + 4'h1;
                if (pop)  rp_r <= rp_r + 4'h1;
                lvl_r <= lvl_r + {4'h0, push} - {4'h0, pop};
                rd_vld_r <= !empty && !(pop && lvl_r == 5'h01 && !push);
                if (lw_word || lr_beat) half_r <= p16_r && !half_r;
                if (lw_word && !half_r) hold_r <= local_wdata[31:16];
            end
            // Read data onto the local lanes, first half upper pair (little) or swapped lower pair (big).
            if (boc_r) begin
                local_rdata <= p16_r ? (half_r ?
                    {swap16(fif.rd_data[31:16]), 16'h0} :
                    {swap16(fif.rd_data[15:0]), 16'h0})
                    : swap32(fif.rd_data);
            end else begin
                local_rdata <= p16_r ? (half_r ?
                    {fif.rd_data[15:0], 16'h0} :
                    {fif.rd_data[31:16], 16'h0})
                    : fif.rd_data;
            end
            local_transfer_size <= p16_r ? 2'h2 : 2'h0;
            local_addr <= (p16_r && (half_r ^ (lw_word | lr_beat)))
                          ? 2'h2 : 2'h0;
            pci_wdata <= fif.rd_data;
            pci_be_n  <= 4'h0;
            transfer_request_line <= req_nxt;
            pci_req <= pci_nxt;
            pci_frame_end <= st_nxt == BDMA_FLUSH || st_nxt == BDMA_HALT;
            // Level interrupts follow their flags; the slave path is
            // never touched here.
            irq_pci_r   <= |(istat & ~idir_r);
            irq_local_r <= |(istat & idir_r);
        end
    end
endmodule // bdma_top

// ==== test/bdma_top_assertions.sv ====
module bdma_checker (
    input wire logic        clk_sys,               // Clock.
    input wire logic        resetn,                // Reset, active low.
    input wire logic        psel,                  // APB select.
    input wire logic        penable,               // APB enable.
    input wire logic        pwrite,                // APB write.
    input wire logic [11:0] paddr,                 // APB address.
    input wire logic        pready,                // APB ready.
    input wire logic        pslverr,               // APB error.
    input wire logic        transfer_request_line, // Service request.
    input wire logic        pci_req,               // PCI word request.
    input wire logic [3:0]  pci_be_n,              // PCI byte enables.
    input wire logic        pci_error,             // PCI error pulse.
    input wire logic        irq_pci_r,             // PCI side interrupt.
    input wire logic        irq_local_r            // Local side interrupt.
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    property p_rdy_ans; psel && !penable |=> pready; endproperty
    a_rdy_ans: assert property (p_rdy_ans)
        else $error("access not answered");
    property p_rdy_one; pready |=> !pready; endproperty
    a_rdy_one: assert property (p_rdy_one)
        else $error("ready longer than one cycle");
    property p_unmap;
        pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 12'h01C);
    endproperty
    a_unmap: assert property (p_unmap)
        else $error("wrong error response");
    property p_pe_drop; pci_error |-> ##[1:4] !transfer_request_line; endproperty
    a_pe_drop: assert property (p_pe_drop)
        else $error("request held after pci error");
    property p_pe_halt; pci_error |-> ##[1:4] !pci_req [*4]; endproperty
    a_pe_halt: assert property (p_pe_halt)
        else $error("pci traffic after pci error");
    sequence s_wr; $past(pready && pwrite, 1) || $past(pready && pwrite, 2) ||
        $past(pready && pwrite, 3); endsequence
    property p_ipci_hold; $fell(irq_pci_r) |-> s_wr; endproperty
    a_ipci_hold: assert property (p_ipci_hold)
        else $error("pci interrupt dropped unprompted");
    property p_iloc_hold; $fell(irq_local_r) |-> s_wr; endproperty
    a_iloc_hold: assert property (p_iloc_hold)
        else $error("local interrupt dropped unprompted");
    property p_be_all; pci_req |-> pci_be_n == 4'h0; endproperty
    a_be_all: assert property (p_be_all)
        else $error("byte enables not all active");
    c_pe: cover property (pci_error ##[1:4] !transfer_request_line);
    c_ipci: cover property ($rose(irq_pci_r));
    c_iloc: cover property ($rose(irq_local_r));
endmodule // bdma_checker

bind bdma_top bdma_checker u_chk (.clk_sys, .resetn, .psel, .penable,
    .pwrite, .paddr, .pready, .pslverr, .transfer_request_line, .pci_req,
    .pci_be_n, .pci_error, .irq_pci_r, .irq_local_r);

// ==== test/bdma_far_model.sv ====
module bdma_far_model (
    input wire logic        clk_sys,               // Clock.
    input wire logic        resetn,                // Reset, active low.
    input wire logic        slow,                  // Stall both sides.
    input wire logic        transfer_request_line, // Service request.
    input wire logic        pci_req,               // PCI word request.
    input wire logic        pci_frame_end,         // Stop burst.
    output logic            transfer_acknowledge,  // Local beat strobe.
    output logic            pci_ack,               // PCI word done.
    output logic            pci_burst_active,      // Burst running.
    output logic            pci_line_end,          // Line boundary.
    output logic     [31:0] local_wdata,           // Local write lanes.
    output logic     [31:0] pci_rdata              // PCI read word.
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] n_r;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            transfer_acknowledge <= 1'b0;
            pci_ack <= 1'b0;
            n_r <= 2'h0;
        end else begin
            // One beat every other cycle; answers only a standing request.
            transfer_acknowledge <= transfer_request_line && !slow &&
                                    !transfer_acknowledge;
            pci_ack <= pci_req && !slow && !pci_ack && !pci_frame_end;
            if (pci_ack) n_r <= n_r + 2'h1;
        end
    end
    // Outside a beat pci_rdata carries the inverse and local_wdata zero, so stale data is caught.
    assign pci_rdata = pci_ack ? 32'h4433_2211 : ~32'h4433_2211;
    assign local_wdata = transfer_acknowledge ? 32'h8877_6655 : 32'h0;
    assign pci_burst_active = pci_req && !pci_frame_end;
    assign pci_line_end = pci_ack && n_r == 2'h3;
endmodule // bdma_far_model

// ==== test/test_bridge_dma_error_reset_endian.sv ====
module test_bridge_dma_error_reset_endian import bdma_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic slow = 0, local_bus_error = 0, pci_error = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r, local_wdata, local_rdata;
    logic [31:0] pci_rdata, pci_wdata;
    logic pready, pslverr, transfer_request_line, transfer_acknowledge;
    logic pci_req, pci_ack, pci_frame_end, pci_burst_active, pci_line_end;
    logic irq_pci_r, irq_local_r;
    logic [1:0] local_transfer_size, local_addr;
    logic [3:0] pci_be_n;
    int n_mismatch = 0, n_tests = 0, cyc = 0;
    bdma_top dut (.clk_sys, .resetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .transfer_request_line,
        .transfer_acknowledge, .local_wdata, .local_rdata,
        .local_transfer_size, .local_addr, .local_bus_error, .pci_req,
        .pci_ack, .pci_rdata, .pci_wdata, .pci_be_n, .pci_frame_end,
        .pci_burst_active, .pci_line_end, .pci_error, .irq_pci_r,
        .irq_local_r);
    bdma_far_model far (.clk_sys, .resetn, .slow, .transfer_request_line,
        .pci_req, .pci_frame_end, .transfer_acknowledge, .pci_ack,
        .pci_burst_active, .pci_line_end, .local_wdata, .pci_rdata);
    always #2 clk_sys = ~clk_sys;
    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // A hang anywhere ends the run; the tests need well under 5000 cycles.
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys) penable <= 1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1, a, d);
    endtask
    task automatic rd(input logic [11:0] a);
        apb(0, a, 32'h0);
    endtask
    task automatic wait_cs(input int b);
        r = 0;
        repeat (60) if (r[b] !== 1'b1) rd(ADDR_CS);
        chk(r[b], 1);
    endtask
    task automatic t_reset;
        logic [31:0] c;
        wr(ADDR_CS, 32'h8); rd(ADDR_CS); chk(r[CS_CHANNEL_RESET_FLAG], 0);
        slow <= 1; wr(ADDR_INTEN, 32'h1); wr(ADDR_INTDIR, 32'h0);
        wr(ADDR_CNT, 32'h40); wr(ADDR_CS, 32'h3);
        rd(ADDR_CS); chk(r[CS_ACT], 1);
        chk(transfer_request_line, 1);
        rd(ADDR_CNT); c = r;
        wr(ADDR_CS, 32'hA); @(posedge clk_sys);
        chk(transfer_request_line, 0);
        wait_cs(CS_CHANNEL_RESET_FLAG); chk(r[CS_ACT], 0); chk(r[CS_DIR], 1);
        rd(ADDR_CNT); chk(r, c);
        chk(irq_pci_r, 1); chk(irq_local_r, 0);
        rd(ADDR_INTST); chk(r[SRC_RST], 1);
        wr(ADDR_CS, 32'h1000); repeat (2) @(posedge clk_sys);
        chk(irq_pci_r, 0);
        slow <= 0;
        $display("reset sequence test done");
    endtask
    task automatic t_err(input int kind);
        slow <= 1; wr(ADDR_INTEN, 32'h6); wr(ADDR_INTDIR, 32'h6);
        wr(ADDR_CNT, 32'h40); wr(ADDR_CS, 32'h3);
        {local_bus_error, pci_error} <= kind ? 2'b10 : 2'b01;
        @(posedge clk_sys) {local_bus_error, pci_error} <= 2'b00;
        repeat (3) @(posedge clk_sys);
        chk(transfer_request_line, 0);
        rd(ADDR_CS); chk(r[CS_IPE + kind], 1);
        chk(r[CS_IQE - kind], 0);
        chk(irq_local_r, 1); chk(irq_pci_r, 0);
        wr(ADDR_CS, 32'h400 << kind); repeat (2) @(posedge clk_sys);
        chk(irq_local_r, 0); chk(transfer_request_line, 0);
        wr(ADDR_CS, 32'h8); wait_cs(CS_CHANNEL_RESET_FLAG);
        wr(ADDR_CS, 32'h1E00); slow <= 0;
        $display("error test %0d done", kind);
    endtask
    task automatic t_endian;
        logic [31:0] e[4][2];
        logic [31:0] m;
        int k, t;
        e = '{'{32'h44332211, 32'h44332211}, '{32'h11223344, 32'h11223344},
              '{32'h44330000, 32'h22110000}, '{32'h11220000, 32'h33440000}};
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_MISC, i % 2); wr(ADDR_CNT, 32'h10);
            wr(ADDR_CS, (i / 2) << CS_P16 | 1 << CS_GO);
            m = i > 1 ? 32'hFFFF_0000 : 32'hFFFF_FFFF;
            k = 0;
            t = 0;
            while (k < 4 && t < 400) begin
                @(posedge clk_sys);
                t++;
                if (transfer_acknowledge === 1'b1) begin
                    chk(local_rdata & m, e[i][k % 2]);
                    chk(local_addr, i > 1 && k % 2 ? 2'b10 : 2'b00);
                    chk(local_transfer_size, i > 1 ? 2'b10 : 2'b00);
                    k++;
                end
            end
            chk(k, 4);
            wait_cs(CS_DONE); wr(ADDR_CS, 32'h1E00);
        end
        $display("byte order test done");
    endtask
    task automatic t_wpath;
        logic [31:0] e[4];
        int t;
        e = '{32'h8877_6655, 32'h5566_7788, 32'h8877_8877, 32'h7788_7788};
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_MISC, i % 2); wr(ADDR_CNT, 32'h10);
            wr(ADDR_CS, (i / 2) << CS_P16 | 1 << CS_DIR | 1 << CS_GO);
            t = 0;
            while (pci_ack !== 1'b1 && t < 400) begin
                @(posedge clk_sys);
                t++;
            end
            chk(pci_wdata, e[i]);
            chk(pci_be_n, 4'h0);
            wr(ADDR_CS, 32'h8); chk(pci_frame_end, 1);
            wait_cs(CS_CHANNEL_RESET_FLAG); chk(pci_req, 0);
            wr(ADDR_CS, 32'h1E00);
        end
        $display("write path test done");
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        resetn <= 1;
        @(posedge clk_sys);
        rd(ADDR_MISC); chk(r[MISC_BOC], MISC_BOC_RST);
        rd(12'h020); chk(err, 1);
        t_reset();
        t_err(0);
        t_err(1);
        t_endian();
        t_wpath();
        give_verdict();
    end
endmodule // test_bridge_dma_error_reset_endian
